//--- verilog/dlp_device.sv
// attenuator control end: two-wire slave, wiper and setup registers
// Summary of operation
// RULE1: top bits 00/01 pick channel 0/1
// RULE2: low six bits set clamped tap position
// RULE3: top bits 10 load setup bits
// RULE4: setup bits 5..3 ignored
// RULE5: setup bit 2 volatile, wipers power up muted
// RULE6: setup bit 1 enables zero-crossing moves
// RULE7: setup bit 0 picks 33 or 63 taps
// RULE8: bus ignored while enable pin high
// RULE9: address byte 0101, pins, read flag
// RULE10: accept only when pin bits match
// RULE11: command byte follows write address
// RULE12: acknowledge read address, then send data
// RULE13: read order wiper0, wiper1, setup
// RULE14: master acks more, nacks last byte
// RULE15: acked setup byte wraps to wiper0
// RULE16: write starts with flag zero address
// RULE17: stop starts programming in nonvolatile mode
// RULE18: volatile stop programs nothing
// RULE19: top bits 11 do nothing
// RULE20: move at crossing or window end
// RULE21: foreign address ignored until start
// RULE22: no address ack while programming
// RULE23: every written byte decoded alone
module dlp_device #(
   parameter int unsigned ZC_WINDOW = dlp_pkg::ZC_WINDOW_CYC,
   parameter int unsigned EE_WRITE = dlp_pkg::EE_WRITE_CYC
) (
   input wire logic clock,
   input wire logic rst_b,
   dlp_i2c_if.dev bus,
   input wire logic [2:0] addrPins,
   input wire logic [1:0] zcEqual,
   output logic [5:0] wiper0Pos,
   output logic [5:0] wiper1Pos,
   output logic [2:0] setupBits,
   output logic eepromBusy
);
   import dlp_pkg::*;
   typedef struct packed {
      dlp_dev_state_t st;
      logic sclQ;
      logic sdaQ;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] tx;
      logic [1:0] rdIdx;
      logic rw;
      logic ackSeen;
      logic nvDirty;
      logic progReq;
      logic busy;
      logic sdaOe_b;
      logic [2:0] setup;
      logic [1:0][5:0] tgt;
      logic [1:0][5:0] pos;
      logic [1:0] moveWait;
      logic [1:0][CNT_W-1:0] win;
      logic [CNT_W-1:0] eeCnt;
   } dlp_dev_st_t;
   dlp_dev_st_t r;
   dlp_dev_st_t s;
   logic [7:0] syn;
   logic sclIn;
   logic sdaIn;
   logic enB;
   logic [2:0] addrS;
   logic [1:0] zcS;
   logic rise;
   logic fall;
   logic startC;
   logic stopC;
   logic [5:0] maxPos;
   logic [5:0] lim;
   logic [1:0] nIdx;
   logic [7:0] nByte;

   dlp_sync #(.W(8), .INIT(8'hFF)) uSync (
      .clock(clock),
      .rst_b(rst_b),
      .din({zcEqual, addrPins, bus.busEnable_b, bus.sda, bus.scl}),
      .dout(syn)
   );

   always_comb begin
      s = r;
      sclIn = syn[0];
      sdaIn = syn[1];
      enB = syn[2];
      addrS = syn[5:3];
      zcS = syn[7:6];
      rise = sclIn & ~r.sclQ;
      fall = ~sclIn & r.sclQ;
      startC = sclIn & r.sclQ & r.sdaQ & ~sdaIn;
      stopC = sclIn & r.sclQ & ~r.sdaQ & sdaIn;
      maxPos = r.setup[SETUP_TAPER_BIT] ? MUTE_COARSE : MUTE_FINE; // RULE7
      lim = (r.sh[5:0] > maxPos) ? maxPos : r.sh[5:0]; // RULE2
      nIdx = (r.st == DS_ACKA || r.rdIdx == RD_LAST) ? 2'h0 : 2'(r.rdIdx + 2'h1); // RULE15
      case (nIdx) // RULE13
         2'h0: nByte = {CMD_WIPER0, r.tgt[0]};
         2'h1: nByte = {CMD_WIPER1, r.tgt[1]};
         default: nByte = {CMD_SETUP, 3'h0, r.setup};
      endcase
      s.sclQ = sclIn;
      s.sdaQ = sdaIn;
      // pending wiper moves wait for a crossing, bounded by the window
      for (int c = 0; c < 2; c++) begin
         if (r.moveWait[c]) begin
            if (zcS[c] || r.win[c] == CNT_W'(ZC_WINDOW - 1)) begin // RULE20
               s.pos[c] = r.tgt[c];
               s.moveWait[c] = 1'b0;
            end else begin
               s.win[c] = CNT_W'(r.win[c] + 1'b1);
            end
         end
      end
      // programming may only begin once every crossing wait is over
      if (r.busy) begin
         if (r.eeCnt == CNT_W'(EE_WRITE - 1)) begin
            s.busy = 1'b0;
         end else begin
            s.eeCnt = CNT_W'(r.eeCnt + 1'b1);
         end
      end else if (r.progReq && r.moveWait == 2'h0) begin
         s.busy = 1'b1;
         s.eeCnt = '0;
         s.progReq = 1'b0;
      end
      if (enB) begin // RULE8
         s.st = DS_IDLE;
         s.sdaOe_b = 1'b1;
      end else if (startC) begin // RULE9 RULE21
         s.st = DS_ADDR;
         s.cnt = 4'h0;
         s.sdaOe_b = 1'b1;
      end else if (stopC) begin
         s.st = DS_IDLE;
         s.sdaOe_b = 1'b1;
         s.nvDirty = 1'b0;
         if (r.nvDirty && !r.setup[SETUP_STORE_BIT]) begin // RULE17 RULE18
            s.progReq = 1'b1;
         end
      end else begin
         case (r.st)
            DS_ADDR, DS_RXD: begin
               if (rise) begin
                  s.sh = {r.sh[6:0], sdaIn};
                  s.cnt = 4'(r.cnt + 4'h1);
               end else if (fall && r.cnt == BYTE_BITS) begin
                  if (r.st == DS_RXD) begin
                     s.st = DS_ACKW;
                     s.sdaOe_b = 1'b0;
                  end else if (r.sh[7:1] == {ADDR_HIGH, addrS} && !r.busy && !r.progReq) begin // RULE10 RULE22
                     s.st = DS_ACKA;
                     s.sdaOe_b = 1'b0;
                     s.rw = r.sh[0];
                  end else begin
                     s.st = DS_IGN; // RULE21
                  end
               end
            end
            DS_ACKA: begin
               if (fall) begin
                  s.cnt = 4'h0;
                  if (r.rw) begin // RULE12
                     s.st = DS_TXD;
                     s.rdIdx = nIdx;
                     s.tx = nByte;
                     s.sdaOe_b = nByte[7];
                  end else begin // RULE11 RULE16
                     s.st = DS_RXD;
                     s.sdaOe_b = 1'b1;
                  end
               end
            end
            DS_ACKW: begin
               if (fall) begin
                  s.st = DS_RXD;
                  s.cnt = 4'h0;
                  s.sdaOe_b = 1'b1;
                  // each byte is a command of its own, acted on as its ack ends
                  case (r.sh[7:6]) // RULE23
                     CMD_WIPER0, CMD_WIPER1: begin // RULE1 RULE2
                        s.tgt[r.sh[6]] = lim;
                        s.nvDirty = 1'b1;
                        if (r.setup[SETUP_ZC_BIT]) begin // RULE6 RULE20
                           s.moveWait[r.sh[6]] = 1'b1;
                           s.win[r.sh[6]] = '0;
                        end else begin
                           s.pos[r.sh[6]] = lim;
                           s.moveWait[r.sh[6]] = 1'b0;
                        end
                     end
                     CMD_SETUP: begin // RULE3 RULE4
                        s.setup = r.sh[2:0];
                        s.nvDirty = 1'b1;
                     end
                     default: ; // RULE19
                  endcase
               end
            end
            DS_TXD: begin
               if (rise) begin
                  s.cnt = 4'(r.cnt + 4'h1);
               end else if (fall) begin
                  if (r.cnt == BYTE_BITS) begin
                     s.st = DS_ACKR;
                     s.sdaOe_b = 1'b1;
                  end else begin
                     s.tx = {r.tx[6:0], 1'b0};
                     s.sdaOe_b = r.tx[6];
                  end
               end
            end
            DS_ACKR: begin
               if (rise) begin
                  s.ackSeen = ~sdaIn;
               end else if (fall) begin
                  if (r.ackSeen) begin // RULE14 RULE15
                     s.st = DS_TXD;
                     s.cnt = 4'h0;
                     s.rdIdx = nIdx;
                     s.tx = nByte;
                     s.sdaOe_b = nByte[7];
                  end else begin
                     s.st = DS_IGN;
                     s.sdaOe_b = 1'b1;
                  end
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
         r.st <= DS_IDLE;
         r.sclQ <= 1'b1;
         r.sdaQ <= 1'b1;
         r.sdaOe_b <= 1'b1;
         r.setup <= SETUP_RESET[2:0];
         // volatile default: both wipers start at mute of the default taper
         r.tgt <= {2{MUTE_COARSE}}; // RULE5
         r.pos <= {2{MUTE_COARSE}}; // RULE5
      end else begin
         r <= s;
      end
   end

   assign wiper0Pos = r.pos[0];
   assign wiper1Pos = r.pos[1];
   assign setupBits = r.setup;
   assign eepromBusy = r.busy;
   assign bus.sdaDevOut = 1'b0;
   assign bus.sdaDevOe_b = r.sdaOe_b;
endmodule // dlp_device

//--- verilog/dlp_pkg.sv
// shared constants and types for the dual log attenuator control link
package dlp_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned ZC_WINDOW_MS = 50;
   localparam int unsigned ZC_WINDOW_CYC = CLK_HZ / 1000 * ZC_WINDOW_MS;
   localparam int unsigned EE_WRITE_MS = 10;
   localparam int unsigned EE_WRITE_CYC = CLK_HZ / 1000 * EE_WRITE_MS;
   localparam int unsigned SCL_QTR_CYC = 125;
   localparam int CNT_W = 22;
   localparam int QW = 8;
   localparam int AXI_AW = 8;
   localparam logic [3:0] ADDR_HIGH = 4'h5;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [1:0] CMD_WIPER0 = 2'h0;
   localparam logic [1:0] CMD_WIPER1 = 2'h1;
   localparam logic [1:0] CMD_SETUP = 2'h2;
   localparam logic [1:0] RD_LAST = 2'h2;
   localparam logic [7:0] SETUP_RESET = 8'h87;
   localparam int SETUP_STORE_BIT = 2;
   localparam int SETUP_ZC_BIT = 1;
   localparam int SETUP_TAPER_BIT = 0;
   localparam logic [5:0] MUTE_FINE = 6'h3F;
   localparam logic [5:0] MUTE_COARSE = 6'h21;
   localparam logic [AXI_AW-1:0] REG_CMD = 8'h00;
   localparam logic [AXI_AW-1:0] REG_STATUS = 8'h04;
   localparam logic [AXI_AW-1:0] REG_CFG = 8'h08;
   localparam logic [2:0] OP_START = 3'h1;
   localparam logic [2:0] OP_WRITE = 3'h2;
   localparam logic [2:0] OP_READ_ACK = 3'h3;
   localparam logic [2:0] OP_READ_NACK = 3'h4;
   localparam logic [2:0] OP_STOP = 3'h5;
   localparam logic CFG_ENABLE_B_RESET = 1'b1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      DS_IDLE = 3'h0, DS_ADDR = 3'h1, DS_ACKA = 3'h3, DS_RXD = 3'h2,
      DS_ACKW = 3'h6, DS_TXD = 3'h7, DS_ACKR = 3'h5, DS_IGN = 3'h4
   } dlp_dev_state_t;
   typedef enum logic [1:0] {HS_IDLE = 2'h0, HS_START = 2'h1, HS_BYTE = 2'h3, HS_STOP = 2'h2} dlp_host_state_t;
endpackage

//--- verilog/dlp_i2c_if.sv
// two-wire link between bus master and attenuator control
interface dlp_i2c_if;
   logic scl;
   logic sdaHostOut;
   logic sdaHostOe_b;
   logic sdaDevOut;
   logic sdaDevOe_b;
   logic busEnable_b;
   logic sda;
   // open drain with pull-up: any enabled low driver wins
   assign sda = ~((~sdaHostOe_b & ~sdaHostOut) | (~sdaDevOe_b & ~sdaDevOut));
   modport host(output scl, output sdaHostOut, output sdaHostOe_b, output busEnable_b, input sda);
   modport dev(input scl, input sda, input busEnable_b, output sdaDevOut, output sdaDevOe_b);
endinterface

//--- verilog/dlp_sync.sv
// three-stage input synchroniser with agreement filter
module dlp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '1
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   import dlp_pkg::*;
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } dlp_sync_st_t;
   dlp_sync_st_t r;
   dlp_sync_st_t s;
   always_comb begin
      s = r;
      s.s1 = din;
      s.s2 = r.s1;
      s.s3 = r.s2;
      // output follows only when the two later stages agree
      s.q = (r.s2 & r.s3) | (r.q & (r.s2 | r.s3));
   end
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         r <= {4{INIT}};
      end else begin
         r <= s;
      end
   end
   assign dout = r.q;
endmodule // dlp_sync

//--- verilog/dlp_host.sv
// bus master end: AXI4-Lite command registers driving the two-wire link
module dlp_host #(
   parameter int unsigned SCL_QTR = dlp_pkg::SCL_QTR_CYC
) (
   input wire logic clock,
   input wire logic rst_b,
   dlp_i2c_if.host bus,
   input wire logic [dlp_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [dlp_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import dlp_pkg::*;
   typedef struct packed {
      dlp_host_state_t st;
      logic [QW-1:0] qc;
      logic [1:0] ph;
      logic [3:0] bitI;
      logic [2:0] op;
      logic [7:0] txb;
      logic [7:0] rxb;
      logic nackSeen;
      logic scl;
      logic sdaOe_b;
      logic enB;
      logic awGot;
      logic wGot;
      logic [AXI_AW-1:0] awA;
      logic [15:0] wD;
      logic wS;
      logic awRdy;
      logic wRdy;
      logic bVal;
      logic [1:0] bResp;
      logic arRdy;
      logic rVal;
      logic [31:0] rDat;
      logic [1:0] rResp;
   } dlp_host_st_t;
   dlp_host_st_t r;
   dlp_host_st_t s;
   logic sdaIn;
   logic tick;
   logic rdOp;

   dlp_sync #(.W(1), .INIT(1'b1)) uSync (
      .clock(clock),
      .rst_b(rst_b),
      .din(bus.sda),
      .dout(sdaIn)
   );

   always_comb begin
      s = r;
      tick = (r.qc == QW'(SCL_QTR - 1));
      rdOp = (r.op == OP_READ_ACK) || (r.op == OP_READ_NACK);
      s.qc = tick ? '0 : QW'(r.qc + 1'b1);
      if (s_axi_awvalid && r.awRdy) begin
         s.awGot = 1'b1;
         s.awA = s_axi_awaddr;
         s.awRdy = 1'b0;
      end
      if (s_axi_wvalid && r.wRdy) begin
         s.wGot = 1'b1;
         s.wD = s_axi_wdata[15:0];
         s.wS = s_axi_wstrb[0];
         s.wRdy = 1'b0;
      end
      if (r.bVal && s_axi_bready) begin
         s.bVal = 1'b0;
         s.awRdy = 1'b1;
         s.wRdy = 1'b1;
      end
      // each quarter of an scl period is one phase of the current bit
      if (tick && r.st != HS_IDLE) begin
         s.ph = 2'(r.ph + 2'h1);
         case (r.ph)
            2'h0: begin
               if (r.st == HS_START) begin
                  s.sdaOe_b = 1'b1;
               end else if (r.st == HS_STOP) begin
                  s.sdaOe_b = 1'b0;
               end else if (r.bitI == BYTE_BITS) begin
                  s.sdaOe_b = (r.op != OP_READ_ACK); // RULE14
               end else begin
                  s.sdaOe_b = rdOp | r.txb[7];
               end
            end
            2'h1: s.scl = 1'b1;
            2'h2: begin
               if (r.st == HS_START) begin
                  s.sdaOe_b = 1'b0;
               end else if (r.st == HS_STOP) begin
                  s.sdaOe_b = 1'b1; // RULE17
               end else if (r.bitI == BYTE_BITS) begin
                  s.nackSeen = sdaIn;
               end else begin
                  s.rxb = {r.rxb[6:0], sdaIn};
                  s.txb = {r.txb[6:0], 1'b0};
               end
            end
            default: begin
               if (r.st != HS_STOP) begin
                  s.scl = 1'b0;
               end
               if (r.st != HS_BYTE || r.bitI == BYTE_BITS) begin
                  s.st = HS_IDLE;
               end else begin
                  s.bitI = 4'(r.bitI + 4'h1);
               end
            end
         endcase
      end
      if (r.awGot && r.wGot) begin
         s.awGot = 1'b0;
         s.wGot = 1'b0;
         s.bVal = 1'b1;
         s.bResp = RESP_OKAY;
         case (r.awA)
            REG_CMD: begin
               // a command arriving while busy is dropped; poll the busy bit first
               if (r.wS && r.st == HS_IDLE) begin
                  s.op = r.wD[2:0];
                  s.txb = r.wD[15:8]; // RULE1 RULE3 RULE9 RULE11 RULE16 RULE19
                  s.ph = 2'h0;
                  s.bitI = 4'h0;
                  s.qc = '0;
                  case (r.wD[2:0])
                     OP_START: s.st = HS_START;
                     OP_STOP: s.st = HS_STOP;
                     OP_WRITE, OP_READ_ACK, OP_READ_NACK: s.st = HS_BYTE;
                     default: s.st = HS_IDLE;
                  endcase
               end
            end
            REG_CFG: begin
               if (r.wS) begin
                  s.enB = r.wD[0]; // RULE8
               end
            end
            REG_STATUS: ;
            default: s.bResp = RESP_SLVERR;
         endcase
      end
      if (s_axi_arvalid && r.arRdy) begin
         s.arRdy = 1'b0;
         s.rVal = 1'b1;
         s.rResp = RESP_OKAY;
         case (s_axi_araddr)
            REG_CMD: s.rDat = {16'h0000, r.txb, 5'h00, r.op};
            REG_STATUS: s.rDat = {16'h0000, r.rxb, 6'h00, r.nackSeen, r.st != HS_IDLE};
            REG_CFG: s.rDat = {31'h00000000, r.enB};
            default: begin
               s.rDat = 32'h00000000;
               s.rResp = RESP_SLVERR;
            end
         endcase
      end
      if (r.rVal && s_axi_rready) begin
         s.rVal = 1'b0;
         s.arRdy = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
         r.st <= HS_IDLE;
         r.scl <= 1'b1;
         r.sdaOe_b <= 1'b1;
         r.enB <= CFG_ENABLE_B_RESET;
         r.awRdy <= 1'b1;
         r.wRdy <= 1'b1;
         r.arRdy <= 1'b1;
      end else begin
         r <= s;
      end
   end

   assign bus.scl = r.scl;
   assign bus.sdaHostOut = 1'b0;
   assign bus.sdaHostOe_b = r.sdaOe_b;
   assign bus.busEnable_b = r.enB;
   assign s_axi_awready = r.awRdy;
   assign s_axi_wready = r.wRdy;
   assign s_axi_bresp = r.bResp;
   assign s_axi_bvalid = r.bVal;
   assign s_axi_arready = r.arRdy;
   assign s_axi_rdata = r.rDat;
   assign s_axi_rresp = r.rResp;
   assign s_axi_rvalid = r.rVal;
endmodule // dlp_host

//--- testbench/dlp_link_assertions.sv
// concurrent checks on the attenuator end of the two-wire link
module dlp_link_assertions #(
   parameter int unsigned EE_WRITE = 1000
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic scl,
   input wire logic sdaDevOe_b,
   input wire logic busEnable_b,
   input wire logic [5:0] wiper0Pos,
   input wire logic [5:0] wiper1Pos,
   input wire logic [2:0] setupBits,
   input wire logic eepromBusy
);
   logic [31:0] busyCnt_r;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   // counts busy cycles so the programming length is checked without a long repetition
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         busyCnt_r <= 32'h0;
      end else begin
         busyCnt_r <= eepromBusy ? busyCnt_r + 32'h1 : 32'h0;
      end
   end
   chk_disabled_quiet: assert property (busEnable_b [*6] |-> sdaDevOe_b)
      else $error("device drives data line while bus disabled");
   chk_sda_scl_low: assert property ($changed(sdaDevOe_b) |-> !scl)
      else $error("device data changed while clock high");
   chk_busy_no_ack: assert property (eepromBusy |-> sdaDevOe_b)
      else $error("device drives data line while programming");
   chk_busy_length: assert property ($fell(eepromBusy) |-> busyCnt_r == EE_WRITE)
      else $error("programming cycle length wrong");
   chk_volatile_no_prog: assert property ($rose(eepromBusy) |-> !setupBits[2])
      else $error("programming started in volatile mode");
   chk_clamp_ch0: assert property ($changed(wiper0Pos) && setupBits[0] |-> wiper0Pos <= 6'h21)
      else $error("channel 0 tap beyond short taper");
   chk_clamp_ch1: assert property ($changed(wiper1Pos) && setupBits[0] |-> wiper1Pos <= 6'h21)
      else $error("channel 1 tap beyond short taper");
   chk_reset_mute: assert property ($rose(rst_b) |-> wiper0Pos == 6'h21 && wiper1Pos == 6'h21 && setupBits == 3'h7)
      else $error("wrong state after reset");
   cover property ($rose(eepromBusy));
   cover property (!sdaDevOe_b && scl);
   cover property ($changed(wiper1Pos));
endmodule // dlp_link_assertions

//--- testbench/dual_log_pot_i2c_control_tb.sv
// self-checking bench: host and attenuator ends joined over the link
module dual_log_pot_i2c_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dlp_pkg::*;
   localparam int unsigned ZCW = 200;
   // long enough that an address poll ends well inside the programming cycle
   localparam int unsigned EEW = 1000;
   logic clock = 1'h0;
   logic rst_b = 1'h0;
   logic [2:0] addrPins = 3'h5;
   logic [1:0] zcEqual = 2'h0;
   logic [5:0] wiper0Pos, wiper1Pos;
   logic [2:0] setupBits;
   logic eepromBusy;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int fail_count = 0;
   int total_checks = 0;
   dlp_i2c_if link();
   always #10 clock = ~clock;
   dlp_host #(.SCL_QTR(8)) u_dlp_host(.clock(clock), .rst_b(rst_b), .bus(link.host), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   dlp_device #(.ZC_WINDOW(ZCW), .EE_WRITE(EEW)) u_dlp_device(.clock(clock), .rst_b(rst_b), .bus(link.dev),
      .addrPins(addrPins), .zcEqual(zcEqual), .wiper0Pos(wiper0Pos), .wiper1Pos(wiper1Pos),
      .setupBits(setupBits), .eepromBusy(eepromBusy));
   dlp_link_assertions #(.EE_WRITE(EEW)) u_dlp_link_assertions(.clock(clock), .rst_b(rst_b), .scl(link.scl),
      .sdaDevOe_b(link.sdaDevOe_b), .busEnable_b(link.busEnable_b), .wiper0Pos(wiper0Pos),
      .wiper1Pos(wiper1Pos), .setupBits(setupBits), .eepromBusy(eepromBusy));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic hang(input string nm);
      fail_count++;
      $display("[ERR] %s expected done seen timeout", nm);
      end_sim();
   endtask
   task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (n = 0; n < 40; n++) begin
         @(posedge clock);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid === 1'h1) break;
      end
      if (n == 40) hang("axi write");
      r = bresp;
      bready <= 1'h0;
   endtask
   task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (n = 0; n < 40; n++) begin
         @(posedge clock);
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid === 1'h1) break;
      end
      if (n == 40) hang("axi read");
      d = rdata;
      r = rresp;
      rready <= 1'h0;
   endtask
   // issues one link command and polls status until the host is idle again
   task automatic linkOp(input logic [2:0] op, input logic [7:0] b, output logic [31:0] st);
      logic [1:0] r;
      int n;
      axiWr(REG_CMD, {16'h0000, b, 5'h00, op}, r);
      for (n = 0; n < 400; n++) begin
         axiRd(REG_STATUS, st, r);
         if (st[0] === 1'h0) break;
      end
      if (n == 400) hang("link op");
   endtask
   task automatic ctl(input logic [2:0] op);
      logic [31:0] st;
      linkOp(op, 8'h00, st);
   endtask
   task automatic wrB(input logic [7:0] b, input logic nack, input string nm);
      logic [31:0] st;
      linkOp(OP_WRITE, b, st);
      chk(nm, {31'h0, nack}, {31'h0, st[1]});
      // the device acts on a byte only after its synchronised clock fall, a few clocks after host idle
      repeat (8) @(posedge clock);
   endtask
   task automatic rdB(input logic last, input logic [7:0] e, input string nm);
      logic [31:0] st;
      linkOp(last ? OP_READ_NACK : OP_READ_ACK, 8'h00, st);
      chk(nm, {24'h0, e}, {24'h0, st[15:8]});
   endtask
   task automatic t_reset();
      logic [31:0] d;
      logic [1:0] r;
      chk("wiper0 reset", 32'h21, {26'h0, wiper0Pos});
      chk("wiper1 reset", 32'h21, {26'h0, wiper1Pos});
      chk("setup reset", 32'h7, {29'h0, setupBits});
      axiRd(REG_CFG, d, r);
      chk("cfg reset", 32'h1, d & 32'h1);
      axiRd(8'h0C, d, r);
      chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      ctl(OP_START);
      wrB(8'h5A, 1'h1, "addr while disabled");
      ctl(OP_STOP);
      axiWr(REG_CFG, 32'h0, r);
      chk("cfg bresp", {30'h0, RESP_OKAY}, {30'h0, r});
      repeat (10) @(posedge clock);
   endtask
   task automatic t_foreign();
      ctl(OP_START);
      wrB(8'h50, 1'h1, "foreign addr");
      wrB(8'h00, 1'h1, "byte after foreign");
      chk("wiper0 untouched", 32'h21, {26'h0, wiper0Pos});
      ctl(OP_STOP);
   endtask
   task automatic t_volatile();
      ctl(OP_START);
      wrB(8'h5A, 1'h0, "write addr");
      wrB(8'hBC, 1'h0, "setup byte");
      chk("setup bits", 32'h4, {29'h0, setupBits});
      wrB(8'h3F, 1'h0, "wiper0 byte");
      chk("wiper0 full taper", 32'h3F, {26'h0, wiper0Pos});
      wrB(8'h45, 1'h0, "wiper1 byte");
      chk("wiper1", 32'h5, {26'h0, wiper1Pos});
      wrB(8'hC7, 1'h0, "reserved byte");
      chk("reserved wiper0", 32'h3F, {26'h0, wiper0Pos});
      chk("reserved wiper1", 32'h5, {26'h0, wiper1Pos});
      ctl(OP_STOP);
      repeat (20) @(posedge clock);
      chk("volatile stop", 32'h0, {31'h0, eepromBusy});
      ctl(OP_START);
      wrB(8'h5B, 1'h0, "read addr");
      rdB(1'h0, 8'h3F, "read wiper0");
      rdB(1'h0, 8'h45, "read wiper1");
      rdB(1'h0, 8'h84, "read setup");
      rdB(1'h1, 8'h3F, "read wrap");
      ctl(OP_STOP);
   endtask
   task automatic t_taper();
      ctl(OP_START);
      wrB(8'h5A, 1'h0, "taper addr");
      wrB(8'h85, 1'h0, "taper setup");
      wrB(8'h28, 1'h0, "taper wiper0");
      chk("wiper0 clamp", 32'h21, {26'h0, wiper0Pos});
      wrB(8'h4A, 1'h0, "taper wiper1");
      chk("wiper1 in range", 32'hA, {26'h0, wiper1Pos});
      ctl(OP_STOP);
   endtask
   task automatic t_zc_nv();
      int n;
      ctl(OP_START);
      wrB(8'h5A, 1'h0, "zc addr");
      wrB(8'h82, 1'h0, "zc setup");
      wrB(8'h47, 1'h0, "zc wiper1");
      chk("wiper1 held", 32'hA, {26'h0, wiper1Pos});
      repeat (ZCW + 20) @(posedge clock);
      chk("wiper1 after window", 32'h7, {26'h0, wiper1Pos});
      zcEqual <= 2'h1;
      wrB(8'h11, 1'h0, "zc wiper0");
      repeat (10) @(posedge clock);
      chk("wiper0 at crossing", 32'h11, {26'h0, wiper0Pos});
      zcEqual <= 2'h0;
      ctl(OP_STOP);
      for (n = 0; n < 50 && eepromBusy !== 1'h1; n++) @(posedge clock);
      chk("programming started", 32'h1, {31'h0, eepromBusy});
      ctl(OP_START);
      wrB(8'h5A, 1'h1, "poll while busy");
      ctl(OP_STOP);
      for (n = 0; n < 2000 && eepromBusy !== 1'h0; n++) @(posedge clock);
      if (n == 2000) hang("programming end");
      ctl(OP_START);
      wrB(8'h5A, 1'h0, "poll when idle");
      ctl(OP_STOP);
   endtask
   initial begin
      repeat (3) @(posedge clock);
      rst_b <= 1'h1;
      repeat (5) @(posedge clock);
      t_reset();
      t_foreign();
      t_volatile();
      t_taper();
      t_zc_nv();
      end_sim();
   end
endmodule // dual_log_pot_i2c_control_tb
